// ==== pkg/qenc_pkg.sv ====
package qenc_pkg;

   // Sample clock and the fastest edge rate the decoder must follow
   localparam int CLK_HZ = 50_000_000;
   localparam int MAX_INC_PER_S = 250_000;
   localparam int MAX_PHASE_HZ = 62_500;
   // Cycles between two quadrature edges at the fastest documented rate
   localparam int MIN_EDGE_CYC = CLK_HZ / MAX_INC_PER_S;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;

   // Byte addresses of the word registers
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_LATCH = 5'h0C;
   localparam logic [ADDR_W-1:0] ADDR_PRESET = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_SW_ON = 5'h14;
   localparam logic [ADDR_W-1:0] ADDR_SW_OFF = 5'h18;
   localparam logic [ADDR_W-1:0] ADDR_RELOAD = 5'h1C;

   // Reset values and fixed count values
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_007F;
   localparam logic [DATA_W-1:0] PRESET_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] SW_ON_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] SW_OFF_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RELOAD_RST = 32'h0000_0100;
   localparam logic [DATA_W-1:0] COUNT_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0] COUNT_ONE = 32'h0000_0001;
   localparam logic [DATA_W-1:0] COUNT_MAX = 32'hFFFF_FFFF;
   localparam logic [DATA_W-1:0] WRAP_CLR_UP = 32'h0000_4000;
   localparam logic [DATA_W-1:0] WRAP_CLR_DN = 32'hFFFF_C000;

   // Control word, bit 0 is outEnable
   typedef struct packed {
      logic [24:0] rsvd;
      logic setCounter;
      logic output2;
      logic direction_invert;
      logic extResetEnable;
      logic latchEnable;
      logic reloadEnable;
      logic outEnable;
   } ctrl_s;

   // Status word, bit 0 is latchValid
   typedef struct packed {
      logic [22:0] rsvd;
      logic phaseB;
      logic phaseA;
      logic out2;
      logic out1;
      logic capture_pin_state;
      logic overflow;
      logic underflow;
      logic setDone;
      logic latchValid;
   } status_s;

   typedef struct packed {
      logic step;
      logic up;
   } step_s;

   typedef struct packed {
      logic phaseA;
      logic phaseB;
      logic capture;
   } pins_s;

   function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wd,
      input logic [3:0] be
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      return addr[ADDR_W-1:2] == target[ADDR_W-1:2];
   endfunction

endpackage

// ==== verilog/sync_2ff.sv ====
module sync_2ff #(
   parameter int W = 3
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         dout <= '0;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule

// ==== verilog/quad_decoder.sv ====
module quad_decoder (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic phaseA,
   input wire logic phaseB,
   output qenc_pkg::step_s stepOut
);
   import qenc_pkg::*;

   logic aPrev_ff;
   logic bPrev_ff;
   logic primed_ff;
   wire aEdge = phaseA ^ aPrev_ff;
   wire bEdge = phaseB ^ bPrev_ff;
   // Both phases moving at once is an illegal jump, dropped
   wire oneEdge = primed_ff & (aEdge ^ bEdge);
   // A leading B counts up
   wire dirUp = phaseA ^ bPrev_ff;
   step_s nxt_step;

   assign nxt_step = '{step: oneEdge, up: dirUp};

   // Every edge is looked at each cycle, far above the phase rate
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         aPrev_ff <= 1'b0;
         bPrev_ff <= 1'b0;
         primed_ff <= 1'b0;
         stepOut <= '0;
      end else begin
         aPrev_ff <= phaseA;
         bPrev_ff <= phaseB;
         primed_ff <= 1'b1;
         stepOut <= nxt_step;
      end
   end
endmodule

// ==== verilog/quadrature_encoder_counter.sv ====
// Overview of operation
// - Count on every rising and falling edge of both encoder phases.
// - Follow 250,000 increments per second, a 62.5 kHz phase rate.
// - Offer set counter, output switching and reload, plus latching.
// - Count reaching the switch-on threshold turns output 1 on.
// - Count reaching the switch-off threshold turns output 1 off.
// - Output 2 follows the software-written bit only.
// - With output functions disabled, output 1 holds its state.
// - Enabling output functions applies the pending threshold state at once.
// - A new threshold value acts on output 1 immediately.
// - Input 3 is the latch input; its level shows in status.
// - When armed, a high input 3 copies the count into the latch.
// - Latch-valid rises as soon as the latch register is written.
// - One latch per arming; a new enable rising edge rearms.
// - Reload on, counting up: count reaching the limit becomes zero.
// - Reload on, counting down: count at zero loads the limit.
// - Reload acts only while enabled; limit resets to 256.
// - The reload limit sits in its own software-written register.
// - External reset enabled: high input 3 forces the count to zero.
// - Count is unsigned 32-bit and wraps both ways.
// - Wrap flags clear at 0x4000 up, 0xFFFFC000 down, or opposite wrap.
// - A set-counter request loads the preset value into the count.
// - Counting down below the switch-on threshold turns output 1 off.
module quadrature_encoder_counter (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [qenc_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [qenc_pkg::DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [qenc_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic phaseA,
   input wire logic phaseB,
   input wire logic latchIn,
   output logic out1,
   output logic out2
);
   import qenc_pkg::*;

   pins_s pinSync;
   step_s decStep;

   ctrl_s ctrl_ff;
   logic [DATA_W-1:0] preset_ff;
   logic [DATA_W-1:0] swOn_ff;
   logic [DATA_W-1:0] swOff_ff;
   logic [DATA_W-1:0] reload_ff;
   logic [DATA_W-1:0] count_ff;
   logic [DATA_W-1:0] latchVal_ff;
   logic ack_ff;
   logic setPrev_ff;
   logic latchEnPrev_ff;
   logic armed_ff;
   logic latchValid_ff;
   logic setDone_ff;
   logic overflow_ff;
   logic underflow_ff;

   // Pins cross into the clock domain through two flops
   sync_2ff #(
      .W(3)
   ) uSync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .din({phaseA, phaseB, latchIn}),
      .dout(pinSync)
   );

   quad_decoder uDec (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .phaseA(pinSync.phaseA),
      .phaseB(pinSync.phaseB),
      .stepOut(decStep)
   );

   // One wait state per access; read data is fetched in the first cycle
   wire busReq = read | write;
   wire firstCyc = busReq & ~ack_ff;
   wire wrFire = write & ack_ff;
   wire rdLoad = read & firstCyc;

   assign waitrequest = firstCyc;

   wire wrCtrl = wrFire & addr_hit(address, ADDR_CTRL);
   wire wrPreset = wrFire & addr_hit(address, ADDR_PRESET);
   wire wrSwOn = wrFire & addr_hit(address, ADDR_SW_ON);
   wire wrSwOff = wrFire & addr_hit(address, ADDR_SW_OFF);
   wire wrReload = wrFire & addr_hit(address, ADDR_RELOAD);

   wire [DATA_W-1:0] ctrlMerged = be_merge(ctrl_ff, writedata, byteenable);
   ctrl_s nxt_ctrl;
   assign nxt_ctrl = wrCtrl ? ctrl_s'(ctrlMerged & CTRL_MASK) : ctrl_ff;
   wire [DATA_W-1:0] nxt_preset = wrPreset ?
      be_merge(preset_ff, writedata, byteenable) : preset_ff;
   wire [DATA_W-1:0] nxt_swOn = wrSwOn ?
      be_merge(swOn_ff, writedata, byteenable) : swOn_ff;
   wire [DATA_W-1:0] nxt_swOff = wrSwOff ?
      be_merge(swOff_ff, writedata, byteenable) : swOff_ff;
   wire [DATA_W-1:0] nxt_reload = wrReload ?
      be_merge(reload_ff, writedata, byteenable) : reload_ff;

   // Software-requested edges on control bits
   wire setRise = ctrl_ff.setCounter & ~setPrev_ff;
   wire latchRise = ctrl_ff.latchEnable & ~latchEnPrev_ff;

   // Input 3 serves both latch and external reset; software picks one
   wire pin3 = pinSync.capture;
   wire extRst = ctrl_ff.extResetEnable & pin3;

   // Direction and step
   wire goUp = decStep.up ^ ctrl_ff.direction_invert;
   wire stepApplied = decStep.step & ~extRst & ~setRise;
   wire [DATA_W-1:0] incVal = count_ff + COUNT_ONE;
   wire [DATA_W-1:0] decVal = count_ff - COUNT_ONE;
   wire atZero = count_ff == COUNT_ZERO;
   wire atMax = count_ff == COUNT_MAX;
   wire reloadUp = ctrl_ff.reloadEnable & (incVal == reload_ff);
   wire reloadDn = ctrl_ff.reloadEnable & atZero;
   wire [DATA_W-1:0] upVal = reloadUp ? COUNT_ZERO : incVal;
   wire [DATA_W-1:0] dnVal = reloadDn ? reload_ff : decVal;
   wire [DATA_W-1:0] stepVal = goUp ? upVal : dnVal;

   // Set request and reload share this path with plain counting
   wire [DATA_W-1:0] nxt_count = extRst ? COUNT_ZERO :
      setRise ? preset_ff :
      stepApplied ? stepVal : count_ff;

   // Wrap flags
   wire wrapUp = stepApplied & goUp & ~reloadUp & atMax;
   wire wrapDn = stepApplied & ~goUp & ~reloadDn & atZero;
   wire clrUp = stepApplied & goUp & (stepVal == WRAP_CLR_UP);
   wire clrDn = stepApplied & ~goUp & (stepVal == WRAP_CLR_DN);
   wire ovfClr = clrUp | clrDn | wrapDn;
   wire unfClr = clrUp | clrDn | wrapUp;
   wire nxt_overflow = wrapUp | (overflow_ff & ~ovfClr);
   wire nxt_underflow = wrapDn | (underflow_ff & ~unfClr);

   // Set-done stays until software drops the request; set wins
   wire nxt_setDone = setRise | (setDone_ff & ctrl_ff.setCounter);

   // Latch arming and capture, one capture per arming
   wire latchFire = armed_ff & ctrl_ff.latchEnable & pin3;
   wire nxt_armed = latchFire ? 1'b0 : (latchRise | armed_ff);
   wire nxt_latchValid = latchFire | (latchValid_ff & ~latchRise);
   wire [DATA_W-1:0] nxt_latchVal = latchFire ? count_ff : latchVal_ff;

   // Output 1 window: on at or above switch-on, off at or above
   // switch-off when that is equal or higher; level form covers both directions
   wire aboveOn = count_ff >= swOn_ff;
   wire offActive = (swOff_ff >= swOn_ff) & (count_ff >= swOff_ff);
   wire out1Want = aboveOn & ~offActive;
   // Thresholds compare live, so fresh values act next cycle
   wire nxt_out1 = ctrl_ff.outEnable ? out1Want : out1;

   // Read side
   status_s statusWord;
   assign statusWord = '{
      rsvd: '0,
      phaseB: pinSync.phaseB,
      phaseA: pinSync.phaseA,
      out2: out2,
      out1: out1,
      capture_pin_state: pin3,
      overflow: overflow_ff,
      underflow: underflow_ff,
      setDone: setDone_ff,
      latchValid: latchValid_ff
   };

   logic [DATA_W-1:0] rdMux;
   always_comb begin
      rdMux = '0;
      case (address[ADDR_W-1:2])
         ADDR_CTRL[ADDR_W-1:2]: rdMux = ctrl_ff;
         ADDR_STATUS[ADDR_W-1:2]: rdMux = statusWord;
         ADDR_COUNT[ADDR_W-1:2]: rdMux = count_ff;
         ADDR_LATCH[ADDR_W-1:2]: rdMux = latchVal_ff;
         ADDR_PRESET[ADDR_W-1:2]: rdMux = preset_ff;
         ADDR_SW_ON[ADDR_W-1:2]: rdMux = swOn_ff;
         ADDR_SW_OFF[ADDR_W-1:2]: rdMux = swOff_ff;
         ADDR_RELOAD[ADDR_W-1:2]: rdMux = reload_ff;
         default: rdMux = '0;
      endcase
   end

   wire [DATA_W-1:0] nxt_readdata = rdLoad ? rdMux : readdata;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= firstCyc;
      end
   end

   // Read data holds between reads, so a late sampler still sees it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         readdata <= '0;
      end else begin
         readdata <= nxt_readdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= ctrl_s'(CTRL_RST);
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         preset_ff <= PRESET_RST;
      end else begin
         preset_ff <= nxt_preset;
      end
   end

   // Equal thresholds at reset keep out1 off even when enabled
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swOn_ff <= SW_ON_RST;
      end else begin
         swOn_ff <= nxt_swOn;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swOff_ff <= SW_OFF_RST;
      end else begin
         swOff_ff <= nxt_swOff;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reload_ff <= RELOAD_RST;
      end else begin
         reload_ff <= nxt_reload;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= COUNT_RST;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // Flags survive a set; only wraps and the clear points move them
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_ff <= 1'b0;
      end else begin
         overflow_ff <= nxt_overflow;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         underflow_ff <= 1'b0;
      end else begin
         underflow_ff <= nxt_underflow;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         setPrev_ff <= 1'b0;
      end else begin
         setPrev_ff <= ctrl_ff.setCounter;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         setDone_ff <= 1'b0;
      end else begin
         setDone_ff <= nxt_setDone;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         latchEnPrev_ff <= 1'b0;
      end else begin
         latchEnPrev_ff <= ctrl_ff.latchEnable;
      end
   end

   // Armed survives a dropped enable; only a capture disarms
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= nxt_armed;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         latchValid_ff <= 1'b0;
      end else begin
         latchValid_ff <= nxt_latchValid;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         latchVal_ff <= COUNT_RST;
      end else begin
         latchVal_ff <= nxt_latchVal;
      end
   end

   // Output 1 reacts to enable or threshold change within a cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         out1 <= 1'b0;
      end else begin
         out1 <= nxt_out1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         out2 <= 1'b0;
      end else begin
         out2 <= ctrl_ff.output2;
      end
   end
endmodule

// ==== tb/qenc_assertions.sv ====
module qenc_checker import qenc_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [qenc_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [qenc_pkg::DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [qenc_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic phaseA,
   input wire logic phaseB,
   input wire logic latchIn,
   input wire logic out1,
   input wire logic out2
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] ctl_ff;
   logic relWr_ff;
   logic [3:0] hiCnt_ff;
   logic [3:0] nxt_hiCnt;
   wire [2:0] wIdx = address[4:2];
   wire wrDone = write && !waitrequest;
   wire rdDone = read && !waitrequest;
   // Saturates, so a long high level never looks short
   assign nxt_hiCnt = !latchIn ? 4'h0 : hiCnt_ff + 4'(hiCnt_ff != 4'hF);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctl_ff <= '0;
         relWr_ff <= 1'b0;
         hiCnt_ff <= 4'h0;
      end else begin
         if (wrDone && wIdx == 3'h0 && byteenable[0]) begin
            ctl_ff <= writedata[6:0];
         end
         if (wrDone && wIdx == 3'h7) begin
            relWr_ff <= 1'b1;
         end
         hiCnt_ff <= nxt_hiCnt;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   chk_wait_first: assert property (
      (read || write) && !$past(read || write) |-> waitrequest)
      else $error("first access cycle not waited");
   chk_wait_one: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait");
   chk_wait_idle: assert property (
      !(read || write) |-> !waitrequest)
      else $error("wait while idle");
   chk_ctrl_read: assert property (
      rdDone && wIdx == 3'h0 |-> readdata == {25'h0, ctl_ff})
      else $error("control readback wrong");
   chk_out2_follow: assert property (
      out2 == $past(ctl_ff[5]))
      else $error("out2 not following control bit");
   chk_out1_frozen: assert property (
      !ctl_ff[0] |=> $stable(out1))
      else $error("out1 moved while disabled");
   chk_ext_zero: assert property (
      ctl_ff[3] && $past(ctl_ff[3], 3) && hiCnt_ff == 4'hF && rdDone
      && wIdx == 3'h2 |-> readdata == COUNT_ZERO)
      else $error("count not held at zero");
   chk_reload_rst: assert property (
      rdDone && wIdx == 3'h7 && !relWr_ff |-> readdata == RELOAD_RST)
      else $error("reload limit reset value wrong");
   cov_out1_on: cover property ($rose(out1));
   cov_out2_on: cover property ($rose(out2));
   cov_ext_zero: cover property (ctl_ff[3] && hiCnt_ff == 4'hF && rdDone);
endmodule
bind quadrature_encoder_counter qenc_checker u_qenc_checker (
   .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .phaseA(phaseA),
   .phaseB(phaseB), .latchIn(latchIn), .out1(out1), .out2(out2)
);

// ==== tb/enc_model.sv ====
module enc_model import qenc_pkg::*; (
   input wire logic ref_clk,
   output logic phaseA,
   output logic phaseB,
   output logic latchIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   // Gray sequence, A leads B when moving forward
   assign phaseA = ph[0] ^ ph[1];
   assign phaseB = ph[1];
   initial latchIn = 1'b0;
   // One phase edge per step, at the fastest rated spacing
   task automatic move(input int n, input logic up);
      repeat (n) begin
         @(posedge ref_clk);
         ph <= up ? ph + 2'h1 : ph - 2'h1;
         repeat (MIN_EDGE_CYC - 1) @(posedge ref_clk);
      end
   endtask
   task automatic level(input logic v);
      @(posedge ref_clk);
      latchIn <= v;
      repeat (16) @(posedge ref_clk);
   endtask
endmodule

// ==== tb/quadrature_encoder_counter_bench.sv ====
module quadrature_encoder_counter_bench import qenc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] e;
      logic [DATA_W-1:0] m;
   } note_s;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [DATA_W-1:0] writedata = '0;
   logic [3:0] byteenable = 4'hF;
   logic [DATA_W-1:0] readdata;
   logic waitrequest, phaseA, phaseB, latchIn, out1, out2;
   logic [DATA_W-1:0] ctl = '0;
   logic [DATA_W-1:0] pv;
   logic [DATA_W-1:0] pex;
   logic [3:0] bex;
   note_s notes[$];
   note_s nt;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   quadrature_encoder_counter u_quadrature_encoder_counter (
      .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .phaseA(phaseA),
      .phaseB(phaseB), .latchIn(latchIn), .out1(out1), .out2(out2)
   );
   enc_model u_enc_model (
      .ref_clk(ref_clk), .phaseA(phaseA), .phaseB(phaseB), .latchIn(latchIn)
   );
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp_rd(input note_s n, input logic [DATA_W-1:0] s);
      n_checks++;
      if ((s & n.m) !== n.e) begin
         mismatches++;
         $display("mismatch reg %h exp %h seen %h", n.a, n.e, s & n.m);
      end
   endtask
   task automatic pin(input logic two, input logic e);
      logic s;
      repeat (3) @(posedge ref_clk);
      s = two ? out2 : out1;
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch out%0d exp %b seen %b", two + 1, e, s);
      end
   endtask
   // Request held until the edge that sees waitrequest low
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] b = 4'hF);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      byteenable <= b;
      write <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] m);
      notes.push_back(note_s'{a, e & m, m});
      @(posedge ref_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
   endtask
   task automatic ctrl(input logic [DATA_W-1:0] v);
      ctl = v;
      wr(ADDR_CTRL, v);
   endtask
   task automatic setc(input logic [DATA_W-1:0] v);
      wr(ADDR_PRESET, v);
      wr(ADDR_CTRL, ctl | 32'h0000_0040);
      rd(ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
      wr(ADDR_CTRL, ctl);
   endtask
   always @(posedge ref_clk) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         nt = notes.pop_front();
         cmp_rd(nt, readdata);
      end
   end
   // Whole run needs about 10000 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(50501));
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(ADDR_CTRL, CTRL_RST, '1);
      rd(ADDR_RELOAD, RELOAD_RST, '1);
      $display("test reset done");
      pv = $urandom_range(32'h0010_0000, 32'h0000_1000);
      setc(pv);
      rd(ADDR_COUNT, pv, '1);
      u_enc_model.move(8, 1'b1);
      rd(ADDR_COUNT, pv + 8, '1);
      ctrl(32'h0000_0010);
      u_enc_model.move(3, 1'b1);
      rd(ADDR_COUNT, pv + 5, '1);
      ctrl(CTRL_RST);
      $display("test count done");
      setc(COUNT_MAX - 1);
      u_enc_model.move(3, 1'b1);
      rd(ADDR_COUNT, COUNT_ONE, '1);
      rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_000C);
      u_enc_model.move(3, 1'b0);
      rd(ADDR_COUNT, COUNT_MAX - 1, '1);
      rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_000C);
      setc(WRAP_CLR_UP - 2);
      u_enc_model.move(2, 1'b1);
      rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_000C);
      $display("test wrap done");
      wr(ADDR_RELOAD, 32'h0000_0008);
      ctrl(32'h0000_0002);
      setc(32'h0000_0006);
      u_enc_model.move(2, 1'b1);
      rd(ADDR_COUNT, COUNT_ZERO, '1);
      u_enc_model.move(1, 1'b0);
      rd(ADDR_COUNT, 32'h0000_0008, '1);
      ctrl(CTRL_RST);
      setc(COUNT_ZERO);
      u_enc_model.move(1, 1'b0);
      rd(ADDR_COUNT, COUNT_MAX, '1);
      $display("test reload done");
      setc(32'h0000_000A);
      wr(ADDR_SW_ON, 32'h0000_000C);
      wr(ADDR_SW_OFF, 32'h0000_0014);
      ctrl(32'h0000_0001);
      pin(1'b0, 1'b0);
      u_enc_model.move(2, 1'b1);
      pin(1'b0, 1'b1);
      ctrl(CTRL_RST);
      u_enc_model.move(8, 1'b1);
      pin(1'b0, 1'b1);
      ctrl(32'h0000_0001);
      pin(1'b0, 1'b0);
      u_enc_model.move(9, 1'b0);
      pin(1'b0, 1'b0);
      wr(ADDR_SW_ON, 32'h0000_0005);
      pin(1'b0, 1'b1);
      ctrl(32'h0000_0021);
      pin(1'b1, 1'b1);
      ctrl(CTRL_RST);
      pin(1'b1, 1'b0);
      $display("test outputs done");
      setc(32'h0000_0064);
      ctrl(32'h0000_0004);
      u_enc_model.level(1'b1);
      rd(ADDR_STATUS, 32'h0000_0011, 32'h0000_0011);
      u_enc_model.level(1'b0);
      rd(ADDR_LATCH, 32'h0000_0064, '1);
      u_enc_model.move(4, 1'b1);
      u_enc_model.level(1'b1);
      u_enc_model.level(1'b0);
      rd(ADDR_LATCH, 32'h0000_0064, '1);
      ctrl(CTRL_RST);
      ctrl(32'h0000_0004);
      rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
      u_enc_model.level(1'b1);
      u_enc_model.level(1'b0);
      rd(ADDR_LATCH, 32'h0000_0068, '1);
      $display("test latch done");
      ctrl(CTRL_RST);
      ctrl(32'h0000_0008);
      u_enc_model.level(1'b1);
      rd(ADDR_COUNT, COUNT_ZERO, '1);
      u_enc_model.level(1'b0);
      u_enc_model.move(2, 1'b1);
      rd(ADDR_COUNT, 32'h0000_0002, '1);
      $display("test external reset done");
      bex = 4'($urandom_range(14, 1));
      pv = $urandom;
      wr(ADDR_PRESET, COUNT_ZERO);
      wr(ADDR_PRESET | 5'h03, pv, bex);
      for (int i = 0; i < 4; i++) begin
         pex[i*8 +: 8] = bex[i] ? pv[i*8 +: 8] : 8'h00;
      end
      rd(ADDR_PRESET, pex, '1);
      $display("test byte lanes done");
      @(posedge ref_clk);
      if (notes.size() != 0) begin
         mismatches++;
      end
      print_verdict();
   end
endmodule
